// File: hdl/gti_target.sv
// Purpose: two-wire target engine with command space and stretching
// Assumes: line inputs synchronous to core_clk_in, open-drain pads
// Notes: an output enable low means the line is pulled low
`timescale 1ns/1ps
`default_nettype none
module gti_target
  import gti_pkg::*;
#(
  parameter int HALF_CYC = HALF_SEC_CYC,
  parameter int STRETCH_CAP = STRETCH_MAX_CYC
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // open-drain lines
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_b_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b_out,
  // core side
  input wire gti_mode_e power_mode_in,
  input wire logic core_busy_in,
  input wire logic last_used_profile_flag_in,
  input wire logic [7:0] timeout_count_in,
  input wire logic core_wr_en_in,
  input wire gti_wr_s core_wr_in,
  // events to the core
  output logic host_wr_valid_out,
  output var gti_wr_s host_wr_out,
  output logic wake_req_out,
  output logic engine_sleep_out
);
  logic scl_q, scl_p, sda_q, sda_p;
  gti_state_e st_q, st_d;
  logic [3:0] bitc_q, bitc_d;
  logic [7:0] shf_q, shf_d;
  logic [6:0] ptr_q, ptr_d;
  logic rw_q, rw_d, ack_q, ack_d, drv_q, drv_d;
  logic wr_go, wake_go;
  logic [7:0] mem_q [MEM_DEPTH];
  logic [WAKE_W-1:0] wake_cnt_q;
  logic busy_hold_q;
  logic [CAP_W-1:0] cap_q;
  logic [2:0] chk_q;
  logic expire;

  // edge and condition decode
  wire rise = scl_q && !scl_p;
  wire fall = !scl_q && scl_p;
  wire start = scl_q && scl_p && sda_p && !sda_q;
  wire stop = scl_q && scl_p && !sda_p && sda_q;
  wire full = (bitc_q == BITS_PER_BYTE);
  wire byte_end = fall && full;
  wire addr_hit = (shf_q[7:1] == DEV_ADDR); // R2
  wire cmd_ok = (shf_q <= CMD_MAX);
  wire ptr_in = ({1'b0, ptr_q} <= CMD_MAX);
  wire writable = (ptr_q <= RW_CTRL_HI) ||
                  ((ptr_q >= RW_EXT_LO) && (ptr_q <= RW_EXT_HI));
  wire [7:0] rd_byte = (ptr_q == PROF_STATUS_ADDR) ?
                       {7'h00, last_used_profile_flag_in} : // R21
                       (ptr_in ? mem_q[ptr_q] : BYTE_RESET);
  wire asleep_mode = (power_mode_in == GTI_MODE_SLEEP) ||
                     (power_mode_in == GTI_MODE_HIBERNATE);
  wire bus_low = !scl_q || !sda_q;
  wire cap_end = (cap_q == CAP_W'(STRETCH_CAP - 1));
  wire hold = (wake_cnt_q != '0) || busy_hold_q;
  wire addr_fall = (st_q == GTI_ADDR_ACK) && fall;

  // half-second bus-low watchdog
  gti_bus_timer #(.HALF_CYC(HALF_CYC)) u_timer (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .bus_low_in(bus_low),
    .limit_in(timeout_count_in),
    .expire_out(expire)
  );

  // byte engine next-state
  always_comb begin
    st_d = st_q;
    bitc_d = bitc_q;
    shf_d = shf_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    ack_d = ack_q;
    drv_d = drv_q;
    wr_go = 1'b0;
    wake_go = 1'b0;
    if (expire || engine_sleep_out) begin
      st_d = GTI_IDLE; // R8
      drv_d = 1'b0;
    end else if (start) begin
      st_d = GTI_ADDR;
      bitc_d = '0;
      drv_d = 1'b0;
    end else if (stop) begin
      st_d = GTI_IDLE;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        GTI_ADDR, GTI_CMD, GTI_WDATA: begin
          if (rise && !full) begin
            shf_d = {shf_q[6:0], sda_q};
            bitc_d = bitc_q + 4'h1;
          end
          if (byte_end) begin
            bitc_d = '0;
            if (st_q == GTI_ADDR) begin
              st_d = addr_hit ? GTI_ADDR_ACK : GTI_IGNORE; // R24
              drv_d = addr_hit;
              wake_go = addr_hit; // R22 R23
              rw_d = shf_q[0]; // R3
            end else if (st_q == GTI_CMD) begin
              st_d = cmd_ok ? GTI_CMD_ACK : GTI_IGNORE; // R7
              drv_d = cmd_ok;
              ptr_d = shf_q[6:0];
            end else begin
              st_d = writable ? GTI_WDATA_ACK : GTI_IGNORE; // R6
              drv_d = writable;
              wr_go = writable;
              ptr_d = writable ? ptr_q + 7'h01 : ptr_q; // R5
            end
          end
        end
        GTI_ADDR_ACK: begin
          if (fall) begin
            bitc_d = '0;
            st_d = rw_q ? GTI_RDATA : GTI_CMD; // R1
            shf_d = rw_q ? rd_byte : shf_q; // R4
            drv_d = rw_q && !rd_byte[7];
          end
        end
        GTI_CMD_ACK, GTI_WDATA_ACK: begin
          if (fall) begin
            st_d = GTI_WDATA;
            drv_d = 1'b0;
          end
        end
        GTI_RDATA: begin
          if (rise && !full) begin
            bitc_d = bitc_q + 4'h1;
          end
          if (fall && full) begin
            st_d = GTI_RDATA_ACK;
            drv_d = 1'b0;
          end else if (fall) begin
            shf_d = {shf_q[6:0], 1'b0};
            drv_d = !shf_q[6];
          end
        end
        GTI_RDATA_ACK: begin
          if (rise) begin
            ack_d = !sda_q;
            ptr_d = !sda_q ? ptr_q + 7'h01 : ptr_q; // R5
          end
          if (fall) begin
            bitc_d = '0;
            st_d = ack_q ? GTI_RDATA : GTI_IGNORE;
            shf_d = rd_byte;
            drv_d = ack_q && !rd_byte[7];
          end
        end
        default: begin
          drv_d = 1'b0;
        end
      endcase
    end
  end

  // line sampling and engine registers
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {scl_q, scl_p, sda_q, sda_p} <= 4'hF;
      st_q <= GTI_IDLE;
      bitc_q <= '0;
      shf_q <= BYTE_RESET;
      ptr_q <= '0;
      {rw_q, ack_q, drv_q} <= 3'h0;
    end else begin
      {scl_p, scl_q, sda_p, sda_q} <= {scl_q, scl_in, sda_q, sda_in};
      st_q <= st_d;
      bitc_q <= bitc_d;
      shf_q <= shf_d;
      ptr_q <= ptr_d;
      {rw_q, ack_q, drv_q} <= {rw_d, ack_d, drv_d};
    end
  end

  // command space; a host write wins over a core write to the same cycle
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_q[i] <= BYTE_RESET;
      end
    end else if (wr_go) begin
      mem_q[ptr_q] <= shf_q;
    end else if (core_wr_en_in && ({1'b0, core_wr_in.addr} <= CMD_MAX)) begin
      mem_q[core_wr_in.addr] <= core_wr_in.data;
    end
  end

  // clock stretch: short wake stretch, then core-busy stretch with a cap
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wake_cnt_q <= '0;
      busy_hold_q <= 1'b0;
      cap_q <= '0;
    end else begin
      if (expire) begin
        wake_cnt_q <= '0; // R8
      end else if (start && asleep_mode) begin
        wake_cnt_q <= WAKE_LOAD; // R14
      end else if (wake_cnt_q != '0) begin
        wake_cnt_q <= wake_cnt_q - 1'b1;
      end
      if (expire || !core_busy_in || cap_end) begin
        busy_hold_q <= 1'b0; // R17 R18 R19 R20
      end else if (addr_fall && core_busy_in) begin
        busy_hold_q <= 1'b1; // R15
      end
      cap_q <= busy_hold_q ? cap_q + 1'b1 : '0;
    end
  end

  // line drivers, release check after timeout and event outputs
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_b_out <= 1'b1;
      sda_oe_b_out <= 1'b1;
      chk_q <= '0;
      engine_sleep_out <= 1'b0;
      host_wr_valid_out <= 1'b0;
      host_wr_out <= '0;
      wake_req_out <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_b_out <= !(hold && !expire && (!scl_q || !scl_oe_b_out));
      sda_oe_b_out <= !drv_d;
      chk_q <= expire ? CHECK_LOAD : (chk_q != '0 ? chk_q - 3'h1 : chk_q);
      if (chk_q == 3'h1 && bus_low) begin
        engine_sleep_out <= 1'b1; // R9
      end else if (scl_q && sda_q) begin
        engine_sleep_out <= 1'b0;
      end
      host_wr_valid_out <= wr_go;
      host_wr_out <= wr_go ? {ptr_q, shf_q} : host_wr_out;
      wake_req_out <= wake_go;
    end
  end

  // checks
  sequence s_addr_done;
    (st_q == GTI_ADDR) && byte_end && !expire && !engine_sleep_out &&
      !start && !stop;
  endsequence
  sequence s_data_done;
    (st_q == GTI_WDATA) && byte_end && !expire && !engine_sleep_out &&
      !start && !stop;
  endsequence

  AST_ADDR_ACK: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R2
    s_addr_done and addr_hit |=> !sda_oe_b_out ##0 wake_req_out)
    else $error("own address not acknowledged");
  AST_FOREIGN: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R24
    s_addr_done and !addr_hit |=> sda_oe_b_out && !wake_req_out)
    else $error("foreign address touched the bus");
  AST_CMD_NACK: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R7
    (st_q == GTI_CMD) && byte_end && !cmd_ok && !expire && !engine_sleep_out
      && !start && !stop |=> sda_oe_b_out && (st_q == GTI_IGNORE))
    else $error("high command byte was acknowledged");
  AST_RO_NACK: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R6
    s_data_done and !writable |=> sda_oe_b_out && !host_wr_valid_out)
    else $error("read-only write was acknowledged");
  AST_PTR_INC: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R5
    s_data_done and writable |=> (ptr_q == $past(ptr_q) + 7'h01) ##0
      host_wr_valid_out ##0 (host_wr_out.addr == $past(ptr_q)))
    else $error("pointer did not advance on acknowledged write");
  AST_QUICK: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R4
    (st_q == GTI_ADDR_ACK) && fall && rw_q && !expire && !engine_sleep_out
      && !start && !stop |=> (shf_q == $past(rd_byte)) ##0
      (sda_oe_b_out == $past(rd_byte[7])))
    else $error("read did not start at pointer byte");
  AST_TOUT: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R8
    expire |=> sda_oe_b_out && scl_oe_b_out ##1 (st_q == GTI_IDLE))
    else $error("lines not released on timeout");
  AST_WAKE_STR: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R14
    start && asleep_mode && !expire |=> (wake_cnt_q == WAKE_LOAD))
    else $error("wake stretch not armed");
  AST_NO_FOREIGN_STR: assert property (@(posedge core_clk_in) // R15
    disable iff (!rst_b_in)
    !asleep_mode && (st_q == GTI_IGNORE) && (wake_cnt_q == '0) &&
      !busy_hold_q |=> scl_oe_b_out)
    else $error("stretch on foreign traffic");
  AST_SLEEP: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // R9
    (chk_q == 3'h1) && bus_low |=> engine_sleep_out)
    else $error("engine did not sleep with lines held");
  // wake and host write strobes are single-cycle pulses, busy stretch ends at the cap
  AST_WAKE_PULSE: assert property (@(posedge core_clk_in) // R23
    disable iff (!rst_b_in) wake_req_out |=> !wake_req_out)
    else $error("wake request longer than one cycle");
  AST_WR_PULSE: assert property (@(posedge core_clk_in) // R1
    disable iff (!rst_b_in) host_wr_valid_out |=> !host_wr_valid_out)
    else $error("host write strobe longer than one cycle");
  AST_STR_CAP: assert property (@(posedge core_clk_in) // R20
    disable iff (!rst_b_in) cap_end |=> !busy_hold_q)
    else $error("busy stretch ran past its cap");
endmodule : gti_target
`default_nettype wire

// File: hdl/gti_pkg.sv
// Purpose: shared constants and types of the gauge two-wire target
// Assumes: 50 MHz core clock, open-drain lines sampled synchronously
// Notes: Contract list below is numbered as used in the logic tags
// Contract
// R1: accept read, incremental read, quick read, single and incremental write
// R2: answer only the fixed seven-bit address 1010101
// R3: controller sends 0xAA to write and 0xAB to read
// R4: a read without command byte returns the byte at the current pointer
// R5: pointer advances by one on every acknowledged data byte
// R6: data written to a read-only location is answered with NACK
// R7: a command byte above 0x6B is answered with NACK
// R8: release both lines after bus low for timeout count times half second
// R9: engine sleeps when lines stay low after the timeout release
// R10: host waits 100 ms after checksum, 1.2 s after voltage subcommand
// R11: host allows 2 s before read-write command readback updates
// R12: host issues standard commands at most twice per second
// R13: host leaves 66 us after each STOP before the next transfer
// R14: in sleep and hibernate, stretch briefly on every transfer
// R15: in normal and snooze, stretch only on transfers addressed here
// R16: controller tolerates stretches after start, ack and first read bit
// R17: resistance table update stretches at most 24 ms
// R18: flash block write stretches at most 72 ms
// R19: interrupted flash write recovery stretches at most 116 ms in total
// R20: end of discharge double update stretches at most 144 ms
// R21: status byte 0x6A bit 0 shows last used profile, default 0
// R22: hibernate wakes only on a transfer addressed to this device
// R23: snooze is left on any bus activity with this device
// R24: foreign addresses are not acknowledged and lines are left alone; in sleep and hibernate SCL still gets the wake stretch
package gti_pkg;
  // clock and derived timing
  localparam int CLK_HZ = 50_000_000;
  localparam int WAKE_STRETCH_US = 50;
  localparam int WAKE_CYC = (CLK_HZ / 1_000_000) * WAKE_STRETCH_US;
  localparam int STRETCH_MAX_MS = 144;
  localparam int STRETCH_MAX_CYC = (CLK_HZ / 1000) * STRETCH_MAX_MS;
  localparam int HALF_SEC_MS = 500;
  localparam int HALF_SEC_CYC = (CLK_HZ / 1000) * HALF_SEC_MS;
  localparam int CHECK_CYC = 4;
  // address and command space
  localparam logic [6:0] DEV_ADDR = 7'h55;
  localparam logic [7:0] CMD_MAX = 8'h6B;
  localparam logic [6:0] PROF_STATUS_ADDR = 7'h6A;
  localparam logic [6:0] RW_CTRL_HI = 7'h01;
  localparam logic [6:0] RW_EXT_LO = 7'h3E;
  localparam logic [6:0] RW_EXT_HI = 7'h61;
  localparam int MEM_DEPTH = 108;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int WAKE_W = 12;
  localparam int CAP_W = 23;
  localparam int TOUT_W = 25;
  localparam logic [WAKE_W-1:0] WAKE_LOAD = WAKE_W'(WAKE_CYC);
  localparam logic [2:0] CHECK_LOAD = 3'(CHECK_CYC);

  // power modes reported by the core
  typedef enum logic [1:0] {
    GTI_MODE_NORMAL = 2'h0,
    GTI_MODE_SNOOZE = 2'h1,
    GTI_MODE_SLEEP = 2'h2,
    GTI_MODE_HIBERNATE = 2'h3
  } gti_mode_e;

  // engine states, gray along address, command, data
  typedef enum logic [3:0] {
    GTI_IDLE = 4'h0,
    GTI_ADDR = 4'h1,
    GTI_ADDR_ACK = 4'h3,
    GTI_CMD = 4'h2,
    GTI_CMD_ACK = 4'h6,
    GTI_WDATA = 4'h7,
    GTI_WDATA_ACK = 4'h5,
    GTI_RDATA = 4'h4,
    GTI_RDATA_ACK = 4'hC,
    GTI_IGNORE = 4'hD
  } gti_state_e;

  // one host write into the command space
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } gti_wr_s;
endpackage : gti_pkg

// File: hdl/gti_bus_timer.sv
// Purpose: bus-low watchdog counting half-second units
// Assumes: bus_low_in is a registered level
// Notes: a limit of zero disables the timeout
`timescale 1ns/1ps
`default_nettype none
module gti_bus_timer
  import gti_pkg::*;
#(
  parameter int HALF_CYC = HALF_SEC_CYC
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // bus observation
  input wire logic bus_low_in,
  input wire logic [7:0] limit_in,
  // expiry event
  output logic expire_out
);
  logic [TOUT_W-1:0] cyc_q;
  logic [TOUT_W-1:0] cyc_d;
  logic [7:0] half_q;
  logic [7:0] half_d;
  logic done_q;
  logic done_d;
  logic half_end;
  logic hit;

  // unit and count decode
  assign half_end = (cyc_q == TOUT_W'(HALF_CYC - 1));
  assign hit = half_end && (half_q + 8'h01 == limit_in) && !done_q;
  assign cyc_d = (!bus_low_in || half_end) ? '0 : cyc_q + 1'b1;
  assign half_d = !bus_low_in ? '0 : (half_end ? half_q + 8'h01 : half_q);
  assign done_d = bus_low_in && (done_q || hit);

  // counters, restarted whenever both lines are high
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cyc_q <= '0;
      half_q <= '0;
      done_q <= 1'b0;
      expire_out <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      half_q <= half_d;
      done_q <= done_d;
      expire_out <= hit && bus_low_in && (limit_in != 8'h00); // R8
    end
  end
endmodule : gti_bus_timer
`default_nettype wire

// File: testbench/gti_host_model.sv
// Purpose: bus controller model for the gauge two-wire target
// Assumes: pull-ups on both lines, bus phases of four core clocks
// Notes: stretch waits are bounded; a stuck clock counts in hang_n
`timescale 1ns/1ps
`default_nettype none
module gti_host_model (
  // clock
  input wire logic core_clk_in,
  // wired line levels
  input wire logic scl_line_in,
  input wire logic sda_line_in,
  // controller pull-downs, high means released
  output var logic scl_h_out,
  output var logic sda_h_out
);
  int hang_n = 0;
  // both lines released at time zero
  initial begin
    scl_h_out = 1'b1;
    sda_h_out = 1'b1;
  end
  // wait whole cycles; lines change at the falling edge
  task automatic w(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask : w
  // release the clock and wait out a target stretch of up to 6000 cycles
  task automatic clk_hi();
    int k;
    scl_h_out = 1'b1;
    for (k = 0; k < 6000 && scl_line_in !== 1'b1; k++) w(1);
    if (k == 6000) hang_n++;
    w(4);
  endtask : clk_hi
  // one bit: data set while low, line sampled while high
  task automatic bit_x(input logic b, output logic r);
    sda_h_out = b;
    w(4);
    clk_hi();
    r = sda_line_in;
    scl_h_out = 1'b0;
    w(1);
  endtask : bit_x
  // start condition, also serves as repeated start
  task automatic start();
    sda_h_out = 1'b1;
    w(4);
    clk_hi();
    sda_h_out = 1'b0;
    w(4);
    scl_h_out = 1'b0;
    w(4);
  endtask : start
  // stop condition and the bus-free gap after it
  task automatic stop();
    sda_h_out = 1'b0;
    w(4);
    clk_hi();
    sda_h_out = 1'b1;
    // longer result waits are the core's, this is the floor
    w(3300);
  endtask : stop
  // byte, msb first; ackb high releases the acknowledge slot
  task automatic xb(input logic [7:0] tx, input logic ackb,
    output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(ackb, r);
    ack = ~r;
  endtask : xb
endmodule : gti_host_model
`default_nettype wire

// File: testbench/gti_target_tb.sv
// Purpose: self-checking bench for the gauge two-wire target
// Assumes: short timeout and stretch cap, 50 MHz core clock
// Notes: plain transfers come from a row table, odd cases follow
`timescale 1ns/1ps
`default_nettype none
module gti_target_tb import gti_pkg::*; ;
  localparam int HC = 100;
  localparam int CAP = 200;
  logic k, scl_h, sda_h, scl_o, scl_oe_b, sda_o, sda_oe_b, wake, slp, hv;
  logic core_clk = 1'b0, rst_b = 1'b0, busy = 1'b0, prof_flag = 1'b0;
  gti_mode_e mode = GTI_MODE_NORMAL;
  logic [7:0] tmo = 8'h00, q;
  logic [15:0] d;
  gti_wr_s hw;
  wire logic scl_l, sda_l;
  int fails = 0, n_checks = 0, st_n = 0, wk_n = 0, wv_n = 0, lim;
  // rows: command, first data byte, second data byte
  logic [7:0] rows [3][3] = '{'{8'h00, 8'h5A, 8'hC3},
    '{8'h3E, 8'h81, 8'h7E}, '{8'h60, 8'h0F, 8'hF0}};
  // open-drain lines with pull-ups
  assign scl_l = scl_h & (scl_oe_b | scl_o);
  assign sda_l = sda_h & (sda_oe_b | sda_o);
  // target with shortened counts
  gti_target #(.HALF_CYC(HC), .STRETCH_CAP(CAP)) dut_u (
    .core_clk_in(core_clk), .rst_b_in(rst_b), .scl_in(scl_l),
    .scl_out(scl_o), .scl_oe_b_out(scl_oe_b), .sda_in(sda_l),
    .sda_out(sda_o), .sda_oe_b_out(sda_oe_b), .power_mode_in(mode),
    .core_busy_in(busy), .last_used_profile_flag_in(prof_flag),
    .timeout_count_in(tmo), .core_wr_en_in(1'b0), .core_wr_in('0),
    .host_wr_valid_out(hv), .host_wr_out(hw), .wake_req_out(wake),
    .engine_sleep_out(slp));
  // controller on the far side
  gti_host_model h (.core_clk_in(core_clk), .scl_line_in(scl_l),
    .sda_line_in(sda_l), .scl_h_out(scl_h), .sda_h_out(sda_h));
  // count stretch cycles and wake pulses
  always @(posedge core_clk) begin
    if (scl_oe_b === 1'b0) st_n++;
    if (wake === 1'b1) wk_n++;
    if (hv === 1'b1) wv_n++;
  end
  // run limit and stuck-clock guard
  initial begin
    for (int c = 0; c < 95000 && h.hang_n == 0; c++) @(posedge core_clk);
    fails++;
    complete_run();
  end
  // core clock
  initial forever #10 core_clk = ~core_clk;
  // compare one value
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic complete_run();
    fails += h.hang_n;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  // start, own write address, command byte
  task automatic hdr(input logic [7:0] c, output logic a);
    h.start();
    h.xb(8'hAA, 1'b1, q, a);
    chk(16'(a), 16'h0001);
    h.xb(c, 1'b1, q, a);
  endtask : hdr
  // set pointer, read two bytes, refuse the second
  task automatic rd2(input logic [7:0] c, output logic [15:0] v);
    hdr(c, k);
    h.start();
    h.xb(8'hAB, 1'b1, q, k);
    h.xb(8'hFF, 1'b0, v[15:8], k);
    h.xb(8'hFF, 1'b1, v[7:0], k);
  endtask : rd2
  // reset, table rows, then the odd cases
  initial begin
    h.w(20);
    chk({10'h000, scl_o, sda_o, scl_oe_b, sda_oe_b, slp, wake}, 16'h000C);
    rst_b = 1'b1;
    h.w(2);
    for (int i = 0; i < 3; i++) begin
      hdr(rows[i][0], k);
      h.xb(rows[i][1], 1'b1, q, k);
      chk(16'(k), 16'h0001);
      h.xb(rows[i][2], 1'b1, q, k);
      chk(16'(hw), {1'b0, rows[i][0][6:0] + 7'h01, rows[i][2]});
      rd2(rows[i][0], d);
      chk(d, {rows[i][1], rows[i][2]});
      h.start();
      h.xb(8'hAB, 1'b1, q, k);
      h.xb(8'hFF, 1'b1, q, k);
      chk(16'(q), 16'(rows[i][2]));
      h.stop();
    end
    // command boundary, then a read-only location written
    hdr(8'h6B, k);
    chk(16'(k), 16'h0001);
    hdr(8'h6C, k);
    chk(16'(k), 16'h0000);
    hdr(8'h6A, k);
    h.xb(8'h33, 1'b1, q, k);
    chk(16'(k), 16'h0000);
    chk(16'(hw), 16'h61F0);
    chk(16'(wv_n), 16'h0006);
    // status byte follows the profile flag
    for (int f = 0; f < 2; f++) begin
      prof_flag = f[0];
      rd2(8'h6A, d);
      chk(16'(d[15:8]), 16'(f[0]));
    end
    h.stop();
    // foreign then own address in every power mode
    for (int m = 3; m >= 0; m--) begin
      mode = gti_mode_e'(m);
      st_n = 0;
      wk_n = 0;
      h.start();
      h.xb(8'hAC, 1'b1, q, k);
      chk(16'(k), 16'h0000);
      chk(16'(st_n > 0), 16'(m > 1));
      h.start();
      h.xb(8'hAA, 1'b1, q, k);
      h.stop();
      chk(16'(wk_n), 16'h0001);
    end
    // busy core stretch: capped, then cut by the bus timeout
    busy = 1'b1;
    for (int t = 0; t < 2; t++) begin
      tmo = 8'(t);
      lim = (t == 0) ? CAP : HC;
      st_n = 0;
      h.start();
      h.xb(8'hAA, 1'b1, q, k);
      h.stop();
      chk(16'(st_n > lim - 40 && st_n <= lim + 4), 16'h0001);
    end
    // outside holder keeps both lines low past the timeout
    h.start();
    h.w(HC + 20);
    chk({14'h0000, scl_oe_b, sda_oe_b}, 16'h0003);
    chk(16'(slp), 16'h0001);
    h.stop();
    chk(16'(slp), 16'h0000);
    chk({14'h0000, scl_o, sda_o}, 16'h0000);
    complete_run();
  end
endmodule : gti_target_tb
`default_nettype wire
